/* common/tpf_consts.vh */
// constants for the transmit packet flow and statistics block
//
// Operation
// - between frames insert two to the power of the gap code flags.
// - packet available goes high when fifo fill is below low mark.
// - packet available goes low when fifo fill exceeds high mark.
// - packet available holds its value between the two marks.
// - count bytes of sent non-aborted frames in a 32-bit counter.
// - byte register write snapshots count, restarts at the coincident frame's byte count or 0.
// - byte snapshot readable three clocks after the trigger write.
// - channel monitor write also transfers all these counters.
// - frames of 64k bytes or more add nothing to the byte count.
// - count sent non-aborted frames in a 24-bit counter.
// - frame register write snapshots count, valid three clocks later.
// - gap code sets flags inserted between every pair of frames.
// - next frame starts on complete packet or fill over threshold*16.
// - polarity invert bit inverts the packet available output.
// - count user aborted frames in 16 bits, snapshot like others.
`ifndef TPF_CONSTS_VH
`define TPF_CONSTS_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define TPF_ADDR_CFG        8'hC1
`define TPF_ADDR_CTRL       8'hC2
`define TPF_ADDR_LOW_MARK   8'hC3
`define TPF_ADDR_HIGH_MARK  8'hC4
`define TPF_ADDR_BYTE_B0    8'hC5
`define TPF_ADDR_BYTE_B1    8'hC6
`define TPF_ADDR_BYTE_B2    8'hC7
`define TPF_ADDR_BYTE_B3    8'hC8
`define TPF_ADDR_FRAME_B0   8'hC9
`define TPF_ADDR_FRAME_B1   8'hCA
`define TPF_ADDR_FRAME_B2   8'hCB
`define TPF_ADDR_UABT_B0    8'hCC
`define TPF_ADDR_UABT_B1    8'hCD
`define TPF_ADDR_CHAN_MON   8'h05

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define TPF_CFG_INV_BIT     6
`define TPF_CTRL_GAP_LSB    4
`define TPF_CTRL_THR_LSB    0
`define TPF_RST_CFG         8'h1A
`define TPF_RST_CTRL        8'h24
`define TPF_RST_LOW_MARK    8'h40
`define TPF_RST_HIGH_MARK   8'hF8

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define TPF_SNAP_DELAY      2'd3
`define TPF_BIG_PKT_BYTES   17'h10000

`endif

/* hdl/tpf_flag_gap.v */
// inter-frame flag gap counter and start gate
`timescale 1ns/10ps
`default_nettype none
`include "tpf_consts.vh"

module tpf_flag_gap (
  input  wire       clk_sys,
  input  wire       srst,
  input  wire [3:0] flag_gap_code,
  input  wire       frame_end,
  input  wire       flag_slot,
  output wire       gap_done
);

  reg [15:0] flags_left_q;
  reg        busy_q;

  // ----------------------------------------------------------------
  // load two to the code at frame end, count down one per flag slot
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (srst) begin
      flags_left_q <= 16'h0000;
      busy_q       <= 1'b0;
    end else if (frame_end) begin
      flags_left_q <= 16'h0001 << flag_gap_code;
      busy_q       <= 1'b1;
    end else if (busy_q && flag_slot) begin
      if (flags_left_q == 16'h0001) begin
        busy_q <= 1'b0;
      end
      flags_left_q <= flags_left_q - 16'h0001;
    end
  end

  assign gap_done = ~busy_q & ~frame_end;

endmodule // tpf_flag_gap
`default_nettype wire

/* hdl/tpf_sat_counter.v */
// saturating event counter with snapshot and restart
`timescale 1ns/10ps
`default_nettype none
`include "tpf_consts.vh"

module tpf_sat_counter #(
  parameter WIDTH = 32
) (
  input  wire             clk_sys,
  input  wire             srst,
  input  wire             inc_en,
  input  wire [16:0]      inc_amt,
  input  wire             snap,
  output reg  [WIDTH-1:0] snap_q
);

  reg  [WIDTH-1:0] count_q;
  wire [WIDTH:0]   sum;
  wire [WIDTH-1:0] ones;
  wire [WIDTH-1:0] amt;
  wire [WIDTH+16:0] amt_ext;

  // widen first so the slice stays in range for any counter width
  assign ones    = {WIDTH{1'b1}};
  assign amt_ext = {{WIDTH{1'b0}}, inc_amt};
  assign amt     = amt_ext[WIDTH-1:0];
  assign sum  = {1'b0, count_q} + {1'b0, amt};

  // ----------------------------------------------------------------
  // count with saturation; snapshot restarts at the coincident amount
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (srst) begin
      count_q <= {WIDTH{1'b0}};
      snap_q  <= {WIDTH{1'b0}};
    end else if (snap) begin
      snap_q  <= count_q;
      count_q <= inc_en ? amt : {WIDTH{1'b0}};
    end else if (inc_en) begin
      count_q <= sum[WIDTH] ? ones : sum[WIDTH-1:0];
    end
  end

endmodule // tpf_sat_counter
`default_nettype wire

/* hdl/tpf_top.v */
// transmit fifo flow control, flag gap and statistics counters
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "tpf_consts.vh"

module tpf_top (
  input  wire       clk_sys,
  input  wire       srst,
  // register port
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata_q,
  // fifo and frame state from the same clock domain
  input  wire [8:0] fifo_fill,
  input  wire       fifo_has_packet,
  input  wire       frame_end,
  input  wire       frame_aborted,
  input  wire       frame_user_abort,
  input  wire       byte_sent,
  input  wire       flag_slot,
  // link side
  output reg        packet_available_q,
  output reg        frame_start_ok_q
);

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  reg [7:0] cfg_q;
  reg [7:0] ctrl_q;
  reg [7:0] avail_low_mark_q;
  reg [7:0] avail_high_mark_q;

  wire [3:0] flag_gap_code   = ctrl_q[`TPF_CTRL_GAP_LSB +: 4];
  wire [3:0] start_threshold = ctrl_q[`TPF_CTRL_THR_LSB +: 4];
  wire       avail_polarity_invert = cfg_q[`TPF_CFG_INV_BIT];

  always @(posedge clk_sys) begin
    if (srst) begin
      cfg_q             <= `TPF_RST_CFG;
      ctrl_q            <= `TPF_RST_CTRL;
      avail_low_mark_q  <= `TPF_RST_LOW_MARK;
      avail_high_mark_q <= `TPF_RST_HIGH_MARK;
    end else if (reg_wr) begin
      case (reg_addr)
        `TPF_ADDR_CFG:       cfg_q             <= reg_wdata;
        `TPF_ADDR_CTRL:      ctrl_q            <= reg_wdata;
        `TPF_ADDR_LOW_MARK:  avail_low_mark_q  <= reg_wdata;
        `TPF_ADDR_HIGH_MARK: avail_high_mark_q <= reg_wdata;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // watermark hysteresis for packet available
  // ----------------------------------------------------------------
  reg avail_raw_q;

  always @(posedge clk_sys) begin
    if (srst) begin
      avail_raw_q <= 1'b1;
    end else if (fifo_fill < {1'b0, avail_low_mark_q}) begin
      avail_raw_q <= 1'b1;
    end else if (fifo_fill > {1'b0, avail_high_mark_q}) begin
      avail_raw_q <= 1'b0;
    end
    // between the marks the level is kept
  end

  always @(posedge clk_sys) begin
    if (srst) begin
      packet_available_q <= 1'b0;
    end else begin
      packet_available_q <= avail_raw_q ^ avail_polarity_invert;
    end
  end

  // ----------------------------------------------------------------
  // frame start gate: gap elapsed and enough data stored
  // ----------------------------------------------------------------
  wire gap_done;
  wire fill_over;

  tpf_flag_gap u_gap (
    .clk_sys       (clk_sys),
    .srst          (srst),
    .flag_gap_code (flag_gap_code),
    .frame_end     (frame_end),
    .flag_slot     (flag_slot),
    .gap_done      (gap_done)
  );

  assign fill_over = fifo_fill > {1'b0, start_threshold, 4'h0};

  always @(posedge clk_sys) begin
    if (srst) begin
      frame_start_ok_q <= 1'b0;
    end else begin
      frame_start_ok_q <= gap_done & (fifo_has_packet | fill_over);
    end
  end

  // ----------------------------------------------------------------
  // per-frame byte tally, held back until frame end
  // ----------------------------------------------------------------
  reg [16:0] frame_bytes_q;
  wire       good_end  = frame_end & ~frame_aborted;
  wire       too_big   = frame_bytes_q >= `TPF_BIG_PKT_BYTES;
  wire       byte_inc  = good_end & ~too_big & (frame_bytes_q != 17'h0);

  always @(posedge clk_sys) begin
    if (srst || frame_end) begin
      frame_bytes_q <= 17'h00000;
    end else if (byte_sent && !too_big) begin
      frame_bytes_q <= frame_bytes_q + 17'h00001;
    end
  end

  // ----------------------------------------------------------------
  // snapshot triggers, contents valid three clocks after the write
  // ----------------------------------------------------------------
  wire wr_any   = reg_wr & (reg_addr == `TPF_ADDR_CHAN_MON);
  wire wr_byte  = reg_wr & (reg_addr >= `TPF_ADDR_BYTE_B0) &
                  (reg_addr <= `TPF_ADDR_BYTE_B3);
  wire wr_frame = reg_wr & (reg_addr >= `TPF_ADDR_FRAME_B0) &
                  (reg_addr <= `TPF_ADDR_FRAME_B2);
  wire wr_uabt  = reg_wr & ((reg_addr == `TPF_ADDR_UABT_B0) |
                  (reg_addr == `TPF_ADDR_UABT_B1));

  reg  [1:0] snap_b_q;
  reg  [1:0] snap_f_q;
  reg  [1:0] snap_u_q;

  // a snapshot pulse fires on the second edge after the trigger
  always @(posedge clk_sys) begin
    if (srst) begin
      snap_b_q <= 2'b00;
      snap_f_q <= 2'b00;
      snap_u_q <= 2'b00;
    end else begin
      snap_b_q <= {snap_b_q[0], wr_byte  | wr_any};
      snap_f_q <= {snap_f_q[0], wr_frame | wr_any};
      snap_u_q <= {snap_u_q[0], wr_uabt  | wr_any};
    end
  end

  wire [31:0] byte_snap;
  wire [23:0] frame_snap;
  wire [15:0] uabt_snap;

  tpf_sat_counter #(.WIDTH(32)) u_bytes (
    .clk_sys (clk_sys),
    .srst    (srst),
    .inc_en  (byte_inc),
    .inc_amt (frame_bytes_q),
    .snap    (snap_b_q[1]),
    .snap_q  (byte_snap)
  );

  tpf_sat_counter #(.WIDTH(24)) u_frames (
    .clk_sys (clk_sys),
    .srst    (srst),
    .inc_en  (good_end),
    .inc_amt (17'h00001),
    .snap    (snap_f_q[1]),
    .snap_q  (frame_snap)
  );

  tpf_sat_counter #(.WIDTH(16)) u_uabt (
    .clk_sys (clk_sys),
    .srst    (srst),
    .inc_en  (frame_end & frame_user_abort),
    .inc_amt (17'h00001),
    .snap    (snap_u_q[1]),
    .snap_q  (uabt_snap)
  );

  // ----------------------------------------------------------------
  // read mux, data one cycle after the read strobe
  // ----------------------------------------------------------------
  reg [7:0] rd_mux;

  always @* begin
    case (reg_addr)
      `TPF_ADDR_CFG:       rd_mux = cfg_q;
      `TPF_ADDR_CTRL:      rd_mux = ctrl_q;
      `TPF_ADDR_LOW_MARK:  rd_mux = avail_low_mark_q;
      `TPF_ADDR_HIGH_MARK: rd_mux = avail_high_mark_q;
      `TPF_ADDR_BYTE_B0:   rd_mux = byte_snap[7:0];
      `TPF_ADDR_BYTE_B1:   rd_mux = byte_snap[15:8];
      `TPF_ADDR_BYTE_B2:   rd_mux = byte_snap[23:16];
      `TPF_ADDR_BYTE_B3:   rd_mux = byte_snap[31:24];
      `TPF_ADDR_FRAME_B0:  rd_mux = frame_snap[7:0];
      `TPF_ADDR_FRAME_B1:  rd_mux = frame_snap[15:8];
      `TPF_ADDR_FRAME_B2:  rd_mux = frame_snap[23:16];
      `TPF_ADDR_UABT_B0:   rd_mux = uabt_snap[7:0];
      `TPF_ADDR_UABT_B1:   rd_mux = uabt_snap[15:8];
      default:             rd_mux = 8'h00;
    endcase
  end

  always @(posedge clk_sys) begin
    if (srst) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata_q <= rd_mux;
    end else begin
      reg_rdata_q <= 8'h00;
    end
  end

endmodule // tpf_top
`default_nettype wire

/* test/tpf_checker.sv */
// assertions on flow control, flag gap and mark readback
`timescale 1ns/10ps
`default_nettype none
`include "tpf_consts.vh"

module tpf_checker (
  input wire       clk_sys,
  input wire       srst,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire [7:0] reg_rdata_q,
  input wire [8:0] fifo_fill,
  input wire       fifo_has_packet,
  input wire       frame_end,
  input wire       flag_slot,
  input wire       packet_available_q,
  input wire       frame_start_ok_q
);
  logic [7:0] lo_q, hi_q, cfg_q, ctl_q;
  logic [2:0] qt_q;
  logic       seen_q;
  wire        inv = cfg_q[`TPF_CFG_INV_BIT];
  wire        lo  = fifo_fill < {1'b0, lo_q};
  wire        hi  = fifo_fill > {1'b0, hi_q};
  wire        dok = fifo_has_packet || fifo_fill > {1'b0, ctl_q[3:0], 4'h0};
  // shadow registers, settling count after a write, flag since frame end
  always @(posedge clk_sys) begin
    if (srst) begin
      lo_q   <= `TPF_RST_LOW_MARK;
      hi_q   <= `TPF_RST_HIGH_MARK;
      cfg_q  <= `TPF_RST_CFG;
      ctl_q  <= `TPF_RST_CTRL;
      qt_q   <= 3'h0;
      seen_q <= 1'b1;
    end else begin
      if (reg_wr && reg_addr == `TPF_ADDR_LOW_MARK) lo_q <= reg_wdata;
      if (reg_wr && reg_addr == `TPF_ADDR_HIGH_MARK) hi_q <= reg_wdata;
      if (reg_wr && reg_addr == `TPF_ADDR_CFG) cfg_q <= reg_wdata;
      if (reg_wr && reg_addr == `TPF_ADDR_CTRL) ctl_q <= reg_wdata;
      qt_q   <= reg_wr ? 3'h0 : qt_q + {2'h0, qt_q != 3'h4};
      seen_q <= !frame_end && (flag_slot || seen_q);
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  low_read_a: assert property (reg_rd && reg_addr == `TPF_ADDR_LOW_MARK
    |=> reg_rdata_q == lo_q) else $error("low mark readback");
  high_read_a: assert property (reg_rd && reg_addr == `TPF_ADDR_HIGH_MARK
    |=> reg_rdata_q == hi_q) else $error("high mark readback");
  avail_low_a: assert property (qt_q == 3'h4 && lo && $past(lo)
    && $past(lo, 2) |-> packet_available_q == !inv) else $error("avail low");
  avail_high_a: assert property (qt_q == 3'h4 && hi && $past(hi)
    && $past(hi, 2) |-> packet_available_q == inv) else $error("avail high");
  avail_hold_a: assert property (qt_q == 3'h4 && !$past(lo || hi)
    && !$past(lo || hi, 2) |-> $stable(packet_available_q))
    else $error("avail hold");
  gap_block_a: assert property (frame_end |-> ##2 !frame_start_ok_q)
    else $error("start without gap");
  start_data_a: assert property ($rose(frame_start_ok_q)
    |-> $past(dok) || $past(dok, 2)) else $error("start without data");
  flag_first_a: assert property ($rose(frame_start_ok_q) |-> seen_q)
    else $error("start before flag");
  cover property (reg_wr && reg_addr == `TPF_ADDR_CHAN_MON);
  cover property ($fell(packet_available_q));
  cover property ($rose(frame_start_ok_q));
endmodule // tpf_checker

bind tpf_top tpf_checker u_chk (.clk_sys(clk_sys), .srst(srst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .fifo_fill(fifo_fill),
  .fifo_has_packet(fifo_has_packet), .frame_end(frame_end),
  .flag_slot(flag_slot), .packet_available_q(packet_available_q),
  .frame_start_ok_q(frame_start_ok_q));
`default_nettype wire

/* test/tpf_link_model.sv */
// link side frame source: bytes, frame ends and idle flag slots
`timescale 1ns/10ps
`default_nettype none

module tpf_link_model (
  input  wire        clk_sys,
  input  wire        srst,
  input  wire        go,
  input  wire [16:0] len,
  input  wire        abort,
  input  wire        user,
  output logic       byte_sent,
  output logic       frame_end,
  output logic       frame_aborted,
  output logic       frame_user_abort,
  output logic       flag_slot,
  output logic       busy
);
  logic [16:0] rem_q;
  logic [1:0]  div_q;
  wire         last = busy && rem_q == 17'h0;
  // one byte a cycle then the frame end; qualifiers toggle when unused
  always @(posedge clk_sys) begin
    byte_sent        <= busy && !last;
    frame_end        <= last;
    frame_aborted    <= last ? abort : !frame_aborted;
    frame_user_abort <= last ? user : !frame_user_abort;
    div_q            <= (div_q == 2'h2) ? 2'h0 : div_q + 2'h1;
    flag_slot        <= !busy && div_q == 2'h0;
    if (srst) begin
      busy             <= 1'b0;
      div_q            <= 2'h0;
      frame_aborted    <= 1'b0;
      frame_user_abort <= 1'b0;
    end else if (go && !busy) begin
      busy  <= 1'b1;
      rem_q <= len;
    end else if (busy) begin
      busy  <= !last;
      rem_q <= rem_q - 17'h1;
    end
  end
endmodule // tpf_link_model
`default_nettype wire

/* test/tb.sv */
// bench: marks, flow control, flag gap and statistics counters
`timescale 1ns/10ps
`default_nettype none
`include "tpf_consts.vh"

module tb;
  logic        clk_sys, srst, reg_wr, reg_rd, fifo_has_packet, go, ab, us;
  logic [7:0]  reg_addr, reg_wdata;
  logic [8:0]  fifo_fill;
  logic [16:0] len;
  wire  [7:0]  rdq;
  wire         bs, fe, fa, fu, fs, busy, pav, sok;
  int          n_errors, check_count, cyc, i;

  tpf_top dut (.clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_q(rdq), .fifo_fill(fifo_fill), .frame_end(fe),
    .fifo_has_packet(fifo_has_packet), .frame_aborted(fa),
    .frame_user_abort(fu), .byte_sent(bs), .flag_slot(fs),
    .packet_available_q(pav), .frame_start_ok_q(sok));
  tpf_link_model u_link (.clk_sys(clk_sys), .srst(srst), .go(go),
    .len(len), .abort(ab), .user(us), .byte_sent(bs), .frame_end(fe),
    .frame_aborted(fa), .frame_user_abort(fu), .flag_slot(fs),
    .busy(busy));
  // clock and hang guard
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 90000) begin
      n_errors++;
      print_verdict();
    end
  end
  task automatic cmp(input string w, input [7:0] e, input [7:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic wr(input [7:0] a, input [7:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(input [7:0] a, input [7:0] e);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1;
    cmp("reg_rdata_q", e, rdq);
  endtask
  task automatic rdn(input [7:0] a, input int n, input [31:0] e);
    @(posedge clk_sys); // first read lands three clocks after the trigger
    for (int k = 0; k < n; k++) rd(a + k[7:0], e[8*k +: 8]);
  endtask
  task automatic send(input [16:0] n, input a, input u);
    @(posedge clk_sys);
    go  <= 1'b1;
    len <= n;
    ab  <= a;
    us  <= u;
    @(posedge clk_sys);
    go  <= 1'b0;
    #1;
    for (int k = 0; k < 70000 && busy === 1'b1; k++) @(posedge clk_sys) #1;
    if (busy !== 1'b0) n_errors++;
  endtask
  task automatic pa(input [8:0] f, input e);
    @(posedge clk_sys);
    fifo_fill <= f;
    repeat (4) @(posedge clk_sys);
    #1;
    cmp("packet_available_q", {7'h0, e}, {7'h0, pav});
  endtask
  // count flags from frame end until the next frame may start
  task automatic gap(input [3:0] c);
    logic [7:0] nf;
    wr(`TPF_ADDR_CTRL, {c, 4'h0});
    send(17'd3, 1'b0, 1'b0);
    nf = 8'h0;
    for (int k = 0; k < 99; k++) begin
      if (k > 1 && sok === 1'b1) break;
      if (fs === 1'b1) nf++;
      @(posedge clk_sys) #1;
    end
    cmp("flag gap", 8'h1 << c, nf);
  endtask
  task automatic print_verdict();
    if (n_errors == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    srst = 1'b1;
    fifo_has_packet = 1'b1;
    {reg_wr, reg_rd, go, ab, us} = 5'h00;
    {reg_addr, reg_wdata, len, fifo_fill} = 42'h0;
    repeat (5) @(posedge clk_sys);
    srst <= 1'b0;
    rd(`TPF_ADDR_LOW_MARK, 8'h40);
    rd(`TPF_ADDR_HIGH_MARK, 8'hF8);
    rd(8'h10, 8'h00);
    wr(`TPF_ADDR_LOW_MARK, 8'h50);
    wr(`TPF_ADDR_HIGH_MARK, 8'h90);
    pa(9'h040, 1'b1);
    pa(9'h090, 1'b1);
    pa(9'h091, 1'b0);
    pa(9'h050, 1'b0);
    pa(9'h04F, 1'b1);
    wr(`TPF_ADDR_CFG, 8'h5A);
    pa(9'h04F, 1'b0);
    wr(`TPF_ADDR_CFG, `TPF_RST_CFG);
    for (i = 0; i < 4; i++) gap(i[3:0]);
    wr(`TPF_ADDR_CTRL, 8'h04);
    fifo_has_packet <= 1'b0;
    fifo_fill <= 9'h040;
    send(17'd2, 1'b0, 1'b0);
    repeat (20) @(posedge clk_sys);
    #1;
    cmp("frame_start_ok_q", 8'h0, {7'h0, sok});
    @(posedge clk_sys);
    fifo_fill <= 9'h041;
    repeat (6) @(posedge clk_sys);
    #1;
    cmp("frame_start_ok_q", 8'h1, {7'h0, sok});
    wr(`TPF_ADDR_CHAN_MON, 8'h00);
    send(17'd10, 1'b0, 1'b0);
    send(17'd20, 1'b0, 1'b0);
    send(17'd5, 1'b1, 1'b1);
    send(17'd7, 1'b1, 1'b0);
    wr(`TPF_ADDR_BYTE_B3, 8'h00);
    rdn(`TPF_ADDR_BYTE_B0, 4, 32'd30);
    wr(`TPF_ADDR_BYTE_B0, 8'h00);
    rdn(`TPF_ADDR_BYTE_B0, 4, 32'd0);
    wr(`TPF_ADDR_FRAME_B2, 8'h00);
    rdn(`TPF_ADDR_FRAME_B0, 3, 32'd2);
    wr(`TPF_ADDR_UABT_B1, 8'h00);
    rdn(`TPF_ADDR_UABT_B0, 2, 32'd1);
    send(17'd4, 1'b0, 1'b0);
    wr(`TPF_ADDR_CHAN_MON, 8'h00);
    rdn(`TPF_ADDR_BYTE_B0, 4, 32'd4);
    rdn(`TPF_ADDR_FRAME_B0, 3, 32'd1);
    // transfer timed onto the frame end: restart at the event amount
    fork
      send(17'd6, 1'b0, 1'b0);
      begin
        repeat (6) @(posedge clk_sys);
        wr(`TPF_ADDR_CHAN_MON, 8'h00);
      end
    join
    wr(`TPF_ADDR_CHAN_MON, 8'h00);
    rdn(`TPF_ADDR_BYTE_B0, 4, 32'd6);
    rdn(`TPF_ADDR_FRAME_B0, 3, 32'd1);
    send(17'h10000, 1'b0, 1'b0);
    wr(`TPF_ADDR_CHAN_MON, 8'h00);
    rdn(`TPF_ADDR_BYTE_B0, 4, 32'd0);
    print_verdict();
  end
endmodule // tb
`default_nettype wire
